/* File: can_msg_object_arbitration.sv */
// Purpose: arbitration and validity part of two message objects with their registers
// Assumes: frame core on core_clk offers received frames and takes transmit requests
// Notes: read data stand one cycle after the read strobe
//
// Behaviour
// [R1] Invalid object ignored for everything
// [R2] Valid object takes part in processing
// [R3] Software clears unused objects before start
// [R4] Software clears valid before changing fields
// [R5] Select bit picks short or long label
// [R6] Receive object with request sends remote frame
// [R7] Matching data frame stored in receive object
// [R8] Transmit object with request sends data
// [R9] Matching remote sets request if enabled
// [R10] Long label joins upper and lower fields
// [R11] Short label from upper bits 12:2
// [R12] Upper half of word two reads zero
// [R13] Message control at its two offsets
//
// Decided for this implementation: the address-and-strobe port.

`timescale 1ns/1ps

module can_msg_object_arbitration (
	input wire logic core_clk,
	input wire logic srst,
	input wire logic [11:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [31:0] rdata,
	input wire logic rx_valid,
	input wire can_arb_pkg::frame_t rx_frame,
	output logic rx_store,
	output logic rx_store_idx,
	output logic tx_valid,
	input wire logic tx_ready,
	output can_arb_pkg::frame_t tx_frame,
	output logic tx_idx
);

	// ==========================================================
	// State
	typedef struct packed {
		can_arb_pkg::obj_t [can_arb_pkg::NUM_OBJ-1:0] obj; // Object fields
		logic [31:0] rdata; // Read data register
		logic tx_busy; // Request offered to frame core
		logic tx_idx; // Object being sent
		can_arb_pkg::frame_t tx_frame; // Frame being offered
		logic store; // Store pulse
		logic store_idx; // Object to store into
	} state_t;

	state_t state; // Registered state
	state_t next_state; // Next state
	logic [can_arb_pkg::LABEL_W-1:0] label [can_arb_pkg::NUM_OBJ]; // Assembled labels
	logic [can_arb_pkg::NUM_OBJ-1:0] hit; // Per-object frame match
	can_arb_pkg::dec_t wdec; // Write decode
	can_arb_pkg::dec_t rdec; // Read decode

	// Index ports are one bit wide, so only two objects can be served
	if (can_arb_pkg::NUM_OBJ != 2) begin : g_num_obj_check
		$error("two message objects expected");
	end

	// ==========================================================
	// Address decode
	function automatic can_arb_pkg::dec_t decode(input logic [11:0] a);
		can_arb_pkg::dec_t d;
		d = '{hit: 1'b1, idx: 1'b0, kind: can_arb_pkg::K_NONE};
		case (a)
			can_arb_pkg::OFS_IF1_ARB1: d.kind = can_arb_pkg::K_ARB1;
			can_arb_pkg::OFS_IF1_ARB2: d.kind = can_arb_pkg::K_ARB2;
			can_arb_pkg::OFS_IF1_MCTL: d.kind = can_arb_pkg::K_MCTL;
			can_arb_pkg::OFS_IF2_ARB1: begin
				d.kind = can_arb_pkg::K_ARB1;
				d.idx = 1'b1;
			end
			can_arb_pkg::OFS_IF2_ARB2: begin
				d.kind = can_arb_pkg::K_ARB2;
				d.idx = 1'b1;
			end
			can_arb_pkg::OFS_IF2_MCTL: begin
				d.kind = can_arb_pkg::K_MCTL;
				d.idx = 1'b1;
			end
			default: d.hit = 1'b0;
		endcase
		return d;
	endfunction : decode

	// Pending transfer request of a valid object
	function automatic logic pending(input can_arb_pkg::obj_t o);
		return o.valid && o.mctl[can_arb_pkg::TXRQ_BIT];
	endfunction : pending

	assign wdec = decode(addr);
	assign rdec = decode(addr);

	// ==========================================================
	// Per-object label and match
	for (genvar g = 0; g < can_arb_pkg::NUM_OBJ; g++) begin : g_obj
		// Label for the object's format
		label_assembler u_label (
			.obj(state.obj[g]),
			.label(label[g])
		);
		// Compare with received frame
		object_matcher u_match (
			.obj(state.obj[g]),
			.label(label[g]),
			.frame(rx_frame),
			.hit(hit[g])
		);
	end

	// ==========================================================
	// Next-state logic
	always_comb begin
		next_state = state;
		next_state.store = 1'b0;
		// Transfer accepted by frame core: request done
		if (state.tx_busy && tx_ready) begin
			next_state.tx_busy = 1'b0;
			next_state.obj[state.tx_idx].mctl[can_arb_pkg::TXRQ_BIT] = 1'b0;
		end
		// Software writes
		if (wr && wdec.hit) begin
			case (wdec.kind)
				can_arb_pkg::K_ARB1: next_state.obj[wdec.idx].arb1 = wdata[15:0];
				can_arb_pkg::K_ARB2: begin
					next_state.obj[wdec.idx].valid = wdata[can_arb_pkg::VALID_BIT];
					next_state.obj[wdec.idx].ext = wdata[can_arb_pkg::EXT_BIT];
					next_state.obj[wdec.idx].dir = wdata[can_arb_pkg::DIR_BIT];
					next_state.obj[wdec.idx].hi = wdata[can_arb_pkg::HI_W-1:0];
				end
				can_arb_pkg::K_MCTL: begin
					// [R13] message control word
					next_state.obj[wdec.idx].mctl = wdata[15:0] & can_arb_pkg::MCTL_WMASK;
				end
				default: next_state.obj[wdec.idx] = next_state.obj[wdec.idx];
			endcase
		end
		// Received frame handling, lowest-numbered matching object wins the store
		if (rx_valid) begin
			for (int i = can_arb_pkg::NUM_OBJ - 1; i >= 0; i--) begin
				if (hit[i]) begin
					// [R9] remote sets request
					if (rx_frame.remote && state.obj[i].dir
						&& state.obj[i].mctl[can_arb_pkg::REMOTE_ANSWER_ENABLE_BIT]) begin
						next_state.obj[i].mctl[can_arb_pkg::TXRQ_BIT] = 1'b1;
					end
					// [R7] data frame stored
					if (!rx_frame.remote && !state.obj[i].dir) begin
						next_state.store = 1'b1;
						next_state.store_idx = i[0];
					end
				end
			end
		end
		// [R1] invalidated object drops its offer
		if (state.tx_busy && !next_state.obj[state.tx_idx].valid) begin
			next_state.tx_busy = 1'b0;
		end
		// [R2] valid object with request launches
		if (!state.tx_busy) begin
			for (int i = can_arb_pkg::NUM_OBJ - 1; i >= 0; i--) begin
				if (pending(state.obj[i]) && pending(next_state.obj[i])) begin
					next_state.tx_busy = 1'b1;
					next_state.tx_idx = i[0];
					next_state.tx_frame.label = label[i];
					next_state.tx_frame.ext = state.obj[i].ext;
					// [R6] [R8] direction picks frame kind
					next_state.tx_frame.remote = !state.obj[i].dir;
				end
			end
		end
		// Register read, unmapped reads zero
		next_state.rdata = '0;
		if (rd && rdec.hit) begin
			case (rdec.kind)
				can_arb_pkg::K_ARB1: next_state.rdata = {can_arb_pkg::RSVD_HI,
					state.obj[rdec.idx].arb1};
				can_arb_pkg::K_ARB2: begin
					// [R12] upper half zero
					next_state.rdata = {can_arb_pkg::RSVD_HI, state.obj[rdec.idx].valid,
						state.obj[rdec.idx].ext, state.obj[rdec.idx].dir,
						state.obj[rdec.idx].hi};
				end
				can_arb_pkg::K_MCTL: next_state.rdata = {can_arb_pkg::RSVD_HI,
					state.obj[rdec.idx].mctl};
				default: next_state.rdata = '0;
			endcase
		end
	end

	// ==========================================================
	// State register
	always_ff @(posedge core_clk) begin
		if (srst) begin
			for (int i = 0; i < can_arb_pkg::NUM_OBJ; i++) begin
				state.obj[i] <= '{arb1: can_arb_pkg::RST_WORD, valid: 1'b0, ext: 1'b0,
					dir: 1'b0, hi: '0, mctl: can_arb_pkg::RST_WORD};
			end
			state.rdata <= '0;
			state.tx_busy <= 1'b0;
			state.tx_idx <= 1'b0;
			state.tx_frame <= '0;
			state.store <= 1'b0;
			state.store_idx <= 1'b0;
		end else begin
			state <= next_state;
		end
	end

	// Outputs from the state register
	assign rdata = state.rdata;
	assign rx_store = state.store;
	assign rx_store_idx = state.store_idx;
	assign tx_valid = state.tx_busy;
	assign tx_frame = state.tx_frame;
	assign tx_idx = state.tx_idx;

	// ==========================================================
	// Checks
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (srst);

	// Accepted offer of the frame core
	sequence s_tx_accept;
		tx_valid && tx_ready;
	endsequence

	// Remote frame for a transmit object with answering enabled
	sequence s_remote_hit0;
		rx_valid && rx_frame.remote && hit[0] && state.obj[0].dir
			&& state.obj[0].mctl[can_arb_pkg::REMOTE_ANSWER_ENABLE_BIT];
	endsequence

	// [R1] no offer for invalid object
	a_offer_needs_valid: assert property (tx_valid |-> state.obj[tx_idx].valid) // [R1]
		else $error("offer stands for an invalid object");

	// [R2] pending valid object launches
	a_pending_launch: assert property ( // [R2]
		(!tx_valid && pending(state.obj[0]) && !wr && !rx_valid) |=> tx_valid)
		else $error("pending valid object not offered");

	// [R5] match only on same format
	a_match_format: assert property (hit[0] |-> rx_frame.ext == state.obj[0].ext) // [R5]
		else $error("match across label formats");

	// [R6] [R8] frame kind follows direction
	a_frame_kind: assert property ( // [R8]
		(!tx_valid ##1 tx_valid) |-> tx_frame.remote
			== (tx_idx ? !$past(state.obj[1].dir) : !$past(state.obj[0].dir)))
		else $error("offered frame kind does not follow direction");

	// [R7] matching data frame stored next cycle
	a_store_data: assert property ( // [R7]
		(rx_valid && !rx_frame.remote && hit[0] && !state.obj[0].dir) |=> rx_store)
		else $error("matching data frame not stored");

	// [R9] remote answer sets request
	a_remote_sets: assert property ( // [R9]
		s_remote_hit0 |=> state.obj[0].mctl[can_arb_pkg::TXRQ_BIT])
		else $error("remote frame did not set transfer request");

	// [R9] request cleared after acceptance
	a_accept_clears: assert property ( // [R9]
		(s_tx_accept and (!wr && !rx_valid && !tx_idx)) |=>
			!state.obj[0].mctl[can_arb_pkg::TXRQ_BIT] && !tx_valid)
		else $error("accepted request still pending");

	// [R10] long label joined
	a_long_label: assert property ( // [R10]
		state.obj[0].ext |-> label[0][can_arb_pkg::LABEL_W-1:can_arb_pkg::LO_W]
			== state.obj[0].hi)
		else $error("long label upper part wrong");

	// [R11] short label from upper field
	a_short_label: assert property ( // [R11]
		!state.obj[1].ext |-> label[1] == {18'h00000, state.obj[1].hi[12:2]})
		else $error("short label wrong");

	// [R12] reserved half reads zero
	a_reserved_zero: assert property ( // [R12]
		rd |=> rdata[31:16] == can_arb_pkg::RSVD_HI)
		else $error("reserved bits read nonzero");

	// [R13] second control word readable
	a_mctl_read: assert property ( // [R13]
		(rd && addr == can_arb_pkg::OFS_IF2_MCTL) |=> rdata[15:0] == $past(state.obj[1].mctl))
		else $error("message control two reads wrong");

	// [R12] read data stand one cycle only
	a_idle_read_zero: assert property (!rd |=> rdata == 32'h0) // [R12]
		else $error("read data stood without a read");

	// [R7] store only after a data frame
	a_store_cause: assert property ( // [R7]
		rx_store |-> $past(rx_valid) && !$past(rx_frame.remote))
		else $error("store pulse without a received data frame");

	// [R7] object zero wins a shared store
	a_store_first: assert property ( // [R7]
		(rx_valid && !rx_frame.remote && hit[0] && !state.obj[0].dir) |=> !rx_store_idx)
		else $error("store went past object zero");

	// [R8] offer holds until taken
	a_offer_holds: assert property ( // [R8]
		(tx_valid && !tx_ready && !wr) |=> tx_valid && $stable(tx_frame))
		else $error("offer changed before it was taken");

endmodule : can_msg_object_arbitration

/* File: can_arb_pkg.sv */
// Purpose: shared constants and carrier types for the message-object arbitration block
// Assumes: byte addresses on a 12-bit register port, 32-bit data words
// Notes: two interface register sets, each standing for one message object

package can_arb_pkg;

	// ==========================================================
	// Register map
	localparam logic [11:0] OFS_IF1_ARB1 = 12'h030; // Arbitration word one, set one
	localparam logic [11:0] OFS_IF1_ARB2 = 12'h034; // Arbitration word two, set one
	localparam logic [11:0] OFS_IF1_MCTL = 12'h038; // Message control, set one
	localparam logic [11:0] OFS_IF2_ARB1 = 12'h090; // Arbitration word one, set two
	localparam logic [11:0] OFS_IF2_ARB2 = 12'h094; // Arbitration word two, set two
	localparam logic [11:0] OFS_IF2_MCTL = 12'h098; // Message control, set two

	// ==========================================================
	// Field layout
	localparam int VALID_BIT = 15; // Object valid in word two
	localparam int EXT_BIT = 14; // Long label select in word two
	localparam int DIR_BIT = 13; // Direction in word two
	localparam int HI_W = 13; // Upper label field width
	localparam int LO_W = 16; // Lower label field width
	localparam int LABEL_W = 29; // Long label width
	localparam int STD_W = 11; // Short label width
	localparam int STD_LSB = 2; // Short label starts here in upper field
	localparam int TXRQ_BIT = 8; // Transfer request in message control
	localparam int REMOTE_ANSWER_ENABLE_BIT = 9; // Remote answer enable in message control
	localparam logic [15:0] MCTL_WMASK = 16'hff8f; // Bits 6:4 read-only zero
	localparam logic [15:0] RSVD_HI = 16'h0000; // Upper half of every word
	localparam logic [15:0] RST_WORD = 16'h0000; // Reset of the arb1 and mctl words
	localparam int NUM_OBJ = 2; // Objects behind the two register sets

	// ==========================================================
	// Carrier types
	typedef struct packed {
		logic [15:0] arb1; // Lower label bits
		logic valid; // Object valid
		logic ext; // Long label select
		logic dir; // One is transmit
		logic [12:0] hi; // Upper label bits
		logic [15:0] mctl; // Message control word
	} obj_t;

	typedef struct packed {
		logic [28:0] label; // Frame label, right aligned
		logic ext; // Long label frame
		logic remote; // Remote frame
	} frame_t;

	typedef enum logic [1:0] {
		K_ARB1,
		K_ARB2,
		K_MCTL,
		K_NONE
	} reg_kind_t;

	typedef struct packed {
		logic hit; // Address is mapped
		logic idx; // Object index
		reg_kind_t kind; // Which word
	} dec_t;

endpackage : can_arb_pkg

/* File: label_assembler.sv */
// Purpose: builds the frame label of one object from its two arbitration words
// Assumes: object fields held by the caller
// Notes: purely combinational

`timescale 1ns/1ps

module label_assembler (
	input can_arb_pkg::obj_t obj,
	output logic [can_arb_pkg::LABEL_W-1:0] label
);

	// Short label zero-extended, long label joined from both words
	always_comb begin
		if (obj.ext) begin
			// [R10] long label join
			label = {obj.hi, obj.arb1};
		end else begin
			// [R11] short label only
			label = '0;
			label[can_arb_pkg::STD_W-1:0] = obj.hi[can_arb_pkg::HI_W-1:can_arb_pkg::STD_LSB];
		end
	end

endmodule : label_assembler

/* File: object_matcher.sv */
// Purpose: compares one received frame with one message object
// Assumes: label already assembled for the object's format
// Notes: acceptance masking is not part of this block

`timescale 1ns/1ps

module object_matcher (
	input can_arb_pkg::obj_t obj,
	input logic [can_arb_pkg::LABEL_W-1:0] label,
	input can_arb_pkg::frame_t frame,
	output logic hit
);

	// Exact compare on format and label, only for a valid object
	always_comb begin
		// [R1] invalid never matches
		// [R5] format must agree
		hit = obj.valid && (obj.ext == frame.ext) && (label == frame.label);
	end

endmodule : object_matcher

/* File: testbench.sv */
// Purpose: self-checking bench for the message-object arbitration block
// Assumes: 20 MHz core_clk, synchronous active-high srst
// Notes: one task per scenario; bus driven by non-blocking assignment

`timescale 1ns/1ps

module testbench;
	// ==========================================================
	// Stimulus and observed signals
	logic core_clk = 1'b0; // Core clock
	logic srst = 1'b1; // Reset
	logic [11:0] addr = 12'h000; // Register address
	logic [31:0] wdata = 32'h0; // Write data
	logic wr = 1'b0; // Write strobe
	logic rd = 1'b0; // Read strobe
	logic [31:0] rdata; // Read data
	logic rx_valid = 1'b0; // Received frame strobe
	can_arb_pkg::frame_t rx_frame = '0; // Received frame
	logic rx_store; // Store pulse
	logic rx_store_idx; // Store target
	logic tx_valid; // Offer
	logic tx_ready = 1'b0; // Offer taken
	can_arb_pkg::frame_t tx_frame; // Offered frame
	logic tx_idx; // Offered object
	int n_errors = 0; // Mismatches
	int checks_done = 0; // Comparisons
	int cycles = 0; // Watchdog count
	logic [31:0] v; // Read scratch

	can_msg_object_arbitration dut (.core_clk(core_clk), .srst(srst), .addr(addr),
		.wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .rx_valid(rx_valid),
		.rx_frame(rx_frame), .rx_store(rx_store), .rx_store_idx(rx_store_idx),
		.tx_valid(tx_valid), .tx_ready(tx_ready), .tx_frame(tx_frame), .tx_idx(tx_idx));

	// ==========================================================
	// Clock and watchdog
	initial begin
		forever #25 core_clk = ~core_clk;
	end

	// Cut a hang short
	always @(posedge core_clk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			n_errors = n_errors + 1;
			conclude();
		end
	end

	// ==========================================================
	// Shared tasks
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks_done = checks_done + 1;
		if (seen !== exp) begin
			n_errors = n_errors + 1;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
		@(posedge core_clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge core_clk);
		wr <= 1'b0;
	endtask : wr_reg

	task automatic rd_reg(input logic [11:0] a, output logic [31:0] d);
		@(posedge core_clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge core_clk);
		rd <= 1'b0;
		@(negedge core_clk);
		d = rdata;
	endtask : rd_reg

	// Present one frame, then look at the store pulse
	task automatic send_rx(input can_arb_pkg::frame_t f, input logic st, input logic idx);
		@(posedge core_clk);
		rx_frame <= f;
		rx_valid <= 1'b1;
		@(posedge core_clk);
		rx_valid <= 1'b0;
		@(negedge core_clk);
		chk("rx_store", {31'h0, rx_store}, {31'h0, st});
		if (st) begin
			chk("rx_store_idx", {31'h0, rx_store_idx}, {31'h0, idx});
		end
	endtask : send_rx

	// Wait for an offer, compare it, take it
	task automatic take_tx(input can_arb_pkg::frame_t f, input logic idx);
		for (int i = 0; i < 10 && tx_valid !== 1'b1; i++) begin
			@(negedge core_clk);
		end
		chk("tx_valid", {31'h0, tx_valid}, 32'h1);
		chk("tx_frame", {1'b0, tx_frame}, {1'b0, f});
		chk("tx_idx", {31'h0, tx_idx}, {31'h0, idx});
		@(posedge core_clk);
		tx_ready <= 1'b1;
		@(posedge core_clk);
		tx_ready <= 1'b0;
		@(negedge core_clk);
		chk("tx_valid after accept", {31'h0, tx_valid}, 32'h0);
	endtask : take_tx

	// No offer over a few cycles
	task automatic no_tx();
		for (int i = 0; i < 6; i++) begin
			@(negedge core_clk);
			chk("tx_valid idle", {31'h0, tx_valid}, 32'h0);
		end
	endtask : no_tx

	// ==========================================================
	// Scenarios
	task automatic t_regs();
		wr_reg(12'h034, 32'h0);
		wr_reg(12'h094, 32'h0);
		rd_reg(12'h030, v);
		chk("arb1 reset", v, 32'h0);
		wr_reg(12'h034, 32'hffff1fff);
		rd_reg(12'h034, v);
		chk("arb2 reserved", v, 32'h00001fff);
		// read data gone a cycle later
		@(negedge core_clk);
		chk("rdata after read", rdata, 32'h0);
		wr_reg(12'h098, 32'hfffff6ff);
		rd_reg(12'h098, v);
		chk("mctl two", v, 32'h0000f68f);
		rd_reg(12'h03c, v);
		chk("unmapped", v, 32'h0);
		$display("test regs done");
	endtask : t_regs

	task automatic t_tx_long();
		wr_reg(12'h034, 32'h0);
		wr_reg(12'h030, 32'h00001234);
		wr_reg(12'h034, 32'h0000eabc);
		wr_reg(12'h038, 32'h00000100);
		take_tx({29'h0abc1234, 1'b1, 1'b0}, 1'b0);
		rd_reg(12'h038, v);
		chk("request cleared", v, 32'h0);
		$display("test tx long done");
	endtask : t_tx_long

	task automatic t_short();
		wr_reg(12'h094, 32'h0);
		wr_reg(12'h090, 32'h0000ffff);
		wr_reg(12'h094, 32'h00009694);
		wr_reg(12'h098, 32'h00000100);
		take_tx({29'h000005a5, 1'b0, 1'b1}, 1'b1);
		send_rx({29'h000005a5, 1'b0, 1'b0}, 1'b1, 1'b1);
		send_rx({29'h000005a4, 1'b0, 1'b0}, 1'b0, 1'b0);
		send_rx({29'h000005a5, 1'b1, 1'b0}, 1'b0, 1'b0);
		$display("test short done");
	endtask : t_short

	task automatic t_invalid();
		wr_reg(12'h094, 32'h00001694);
		send_rx({29'h000005a5, 1'b0, 1'b0}, 1'b0, 1'b0);
		wr_reg(12'h098, 32'h00000100);
		no_tx();
		wr_reg(12'h098, 32'h0);
		$display("test invalid done");
	endtask : t_invalid

	task automatic t_remote();
		wr_reg(12'h038, 32'h00000200);
		send_rx({29'h0abc1234, 1'b1, 1'b1}, 1'b0, 1'b0);
		take_tx({29'h0abc1234, 1'b1, 1'b0}, 1'b0);
		rd_reg(12'h038, v);
		chk("enable kept", v, 32'h00000200);
		wr_reg(12'h038, 32'h0);
		send_rx({29'h0abc1234, 1'b1, 1'b1}, 1'b0, 1'b0);
		no_tx();
		$display("test remote done");
	endtask : t_remote

	task automatic t_pair();
		wr_reg(12'h034, 32'h0);
		wr_reg(12'h034, 32'h00009694);
		wr_reg(12'h094, 32'h00009694);
		send_rx({29'h000005a5, 1'b0, 1'b0}, 1'b1, 1'b0);
		wr_reg(12'h098, 32'h00000100);
		@(negedge core_clk);
		@(negedge core_clk);
		chk("remote offer", {31'h0, tx_valid}, 32'h1);
		chk("remote frame", {1'b0, tx_frame}, {1'b0, 29'h000005a5, 1'b0, 1'b1});
		// retiring the object drops its offer
		wr_reg(12'h094, 32'h00001694);
		@(negedge core_clk);
		chk("offer dropped", {31'h0, tx_valid}, 32'h0);
		wr_reg(12'h098, 32'h0);
		no_tx();
		$display("test pair done");
	endtask : t_pair

	// ==========================================================
	// Verdict
	task automatic conclude();
		$display("checks %0d errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : conclude

	// Main sequence
	initial begin
		repeat (3) @(posedge core_clk);
		srst <= 1'b0;
		t_regs();
		t_tx_long();
		t_short();
		t_invalid();
		t_remote();
		t_pair();
		conclude();
	end
endmodule : testbench
